// file: ncr_checker_properties.sv
`timescale 1ns/100ps
module ncr_checker
   import ncr_pkg::*;
#(
   parameter int NUM_CH = 2
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire ncr_ctrl_t ctrl,
   input wire logic test_clock,
   input wire logic mgmt_data_in,
   input wire logic [NUM_CH-1:0] channel_sync_clock,
   input wire logic [NUM_CH-1:0] channel_phase_clock,
   input wire logic [NUM_CH-1:0] channel_serial_clock,
   input wire logic hub_clock_out,
   input wire logic hub_data_valid,
   input wire logic test_clock_core,
   input wire logic mgmt_data_core,
   input wire logic reset_output_n,
   input wire logic core_reset_n,
   input wire logic local_reset_out_n,
   input wire logic proc_init_n,
   input wire ncr_stat_t stat
);
   default clocking cb @(posedge clk_sys); endclocking
   // A frozen clock enable stalls every divider, so attempts across it are dropped.
   default disable iff (!rst_n || !clk_en);
   sync_pair_a: assert property ($past(rst_n) && $past(clk_en) |->
      channel_sync_clock == ($past(core_reset_n) ? $past(channel_phase_clock) : '0))
      else $error("sync clock does not trail phase clock");
   serial_hold_a: assert property (!stat.powerup_done |-> channel_serial_clock == '0)
      else $error("serial clock ran before power-up done");
   hub_div_a: assert property ($changed(hub_clock_out) |=>
      $stable(hub_clock_out) [*2] ##1 $changed(hub_clock_out))
      else $error("hub clock half period wrong");
   hub_xfer_a: assert property ($rose(hub_clock_out) |->
      !hub_data_valid [*3] ##1 hub_data_valid)
      else $error("hub data transfer not three cycles after hub clock");
   reset_out_a: assert property (ctrl.system_hard_reset_bit |=> !reset_output_n)
      else $error("reset output not asserted");
   init_line_a: assert property ((ctrl.init_drive_en && ctrl.soft_reset_bit) [*2]
      |-> !proc_init_n)
      else $error("init line not asserted");
   local_scope_a: assert property (!local_reset_out_n |-> stat.hard_reset_active)
      else $error("local reset outside hard reset");
   hard_pulse_a: assert property ($rose(stat.hard_reset_active) &&
      $past(ctrl.local_reset_bit) |-> stat.hard_reset_active [*8])
      else $error("hard reset too short");
   test_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(clk_en)
      && $past(clk_en, 2) |-> test_clock_core == $past(test_clock, 2))
      else $error("test clock copy not two stages late");
   mgmt_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(clk_en)
      && $past(clk_en, 2) |-> mgmt_data_core == $past(mgmt_data_in, 2))
      else $error("management data copy not two stages late");
endmodule // ncr_checker
bind ncr_clock_reset ncr_checker #(.NUM_CH(NUM_CH)) u_chk (.clk_sys, .rst_n, .clk_en, .ctrl,
   .test_clock, .mgmt_data_in, .channel_sync_clock, .channel_phase_clock, .channel_serial_clock,
   .hub_clock_out, .hub_data_valid, .test_clock_core, .mgmt_data_core, .reset_output_n,
   .core_reset_n, .local_reset_out_n, .proc_init_n, .stat);

// file: ncr_clock_reset.sv
`timescale 1ns/100ps
`include "ncr_params.svh"
module ncr_clock_reset
   import ncr_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int CLK_MHZ = `NCR_REF_MHZ,
   parameter int PLL_LOCK_CYC = `NCR_PLL_LOCK_US * CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic power_good,
   input wire logic reset_input_n,
   input wire logic bus_init_n,
   input wire ncr_ctrl_t ctrl,
   input wire logic [NUM_CH-1:0] channel_fast_req,
   input wire logic hub_return_clock,
   input wire logic hub_data_in,
   input wire logic test_clock,
   input wire logic mgmt_data_in,
   output logic [NUM_CH-1:0] channel_sync_clock,
   output logic [NUM_CH-1:0] channel_phase_clock,
   output logic [NUM_CH-1:0] channel_serial_clock,
   output logic hub_clock_out,
   output logic hub_data_core,
   output logic hub_data_valid,
   output logic test_clock_core,
   output logic mgmt_data_core,
   output logic reset_output_n,
   output logic core_reset_n,
   output logic local_reset_out_n,
   output logic proc_init_n,
   output logic local_mem_keep,
   output ncr_stat_t stat
);
   localparam int PH_DIV = CLK_MHZ / (2 * `NCR_PHASE_MHZ);
   localparam int SLOW_DIV = (CLK_MHZ * 1000) / (2 * `NCR_SERIAL_SLOW_KHZ);
   localparam int HUB_DIV = CLK_MHZ / (2 * `NCR_HUB_MHZ);
   localparam int PHW = 8;
   localparam int PLW = 24;

   // Level synchronizers: the first stage is read only by the second.
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] next_sync1;
   logic [4:0] next_sync2;
   logic pg_s, rin_s, bus_init_n_s, hub_return_clock_s, hdat_s;
   always_comb begin
      next_sync1 = {power_good, reset_input_n, bus_init_n, hub_return_clock, hub_data_in};
      next_sync2 = sync1;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end else if (clk_en) begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end
   assign {pg_s, rin_s, bus_init_n_s, hub_return_clock_s, hdat_s} = sync2;

   // Reset dispatch.
   ncr_state_t state, next_state;
   logic [PLW-1:0] pll_cnt, next_pll_cnt;
   logic [7:0] pulse_cnt, next_pulse_cnt;
   logic first_done, next_first_done;
   logic rin_d, next_rin_d;
   logic rout_n, next_rout_n;
   logic lrst_n, next_lrst_n;
   logic init_n, next_init_n;
   logic keep, next_keep;
   logic core_n, next_core_n;
   ncr_stat_t next_stat;
   always_comb begin
      next_state = state;
      next_pll_cnt = pll_cnt;
      next_pulse_cnt = pulse_cnt;
      next_first_done = first_done;
      next_rin_d = rin_s;
      next_rout_n = 1'b1;
      next_lrst_n = 1'b1;
      next_keep = keep;
      next_core_n = core_n;
      next_init_n = !(ctrl.init_drive_en && ctrl.soft_reset_bit);
      if (ctrl.system_hard_reset_bit) next_rout_n = 1'b0;
      case (state)
         NCR_ST_OFF: begin
            next_core_n = 1'b0;
            next_first_done = 1'b0;
            next_pll_cnt = '0;
            if (pg_s) next_state = NCR_ST_LOCK;
         end
         NCR_ST_LOCK: begin
            next_core_n = 1'b0;
            if (pll_cnt >= PLW'(PLL_LOCK_CYC - 1)) next_state = NCR_ST_PWRUP;
            else next_pll_cnt = pll_cnt + 1'b1;
         end
         NCR_ST_PWRUP: begin
            if (rin_s && !rin_d) begin
               next_core_n = 1'b1;
               next_first_done = 1'b1;
               next_state = NCR_ST_RUN;
            end
         end
         NCR_ST_RUN: begin
            if (!rin_s && rin_d && first_done) begin
               next_core_n = 1'b0;
               next_keep = 1'b0;
               next_state = NCR_ST_HARD;
            end else if (!bus_init_n_s || ctrl.local_reset_bit) begin
               next_core_n = 1'b0;
               next_keep = !bus_init_n_s;
               next_pulse_cnt = 8'(`NCR_RESET_PULSE_CYC);
               next_state = NCR_ST_HARD;
            end
         end
         NCR_ST_HARD: begin
            next_core_n = 1'b0;
            if (ctrl.local_reset_bit) next_lrst_n = 1'b0;
            if (pulse_cnt != 8'h00) next_pulse_cnt = pulse_cnt - 8'h01;
            else if (rin_s && bus_init_n_s) begin
               next_core_n = 1'b1;
               next_lrst_n = 1'b1;
               next_state = NCR_ST_RUN;
            end
         end
         default: next_state = NCR_ST_OFF;
      endcase
      // Losing power-good drops the local reset with the rest, so it never outlives the
      // hard state.
      if (!pg_s) begin
         next_state = NCR_ST_OFF;
         next_lrst_n = 1'b1;
      end
      next_stat = '{hard_reset_active: (next_state == NCR_ST_HARD),
                    local_reset_active: !next_lrst_n,
                    powerup_done: next_first_done,
                    pll_locked: (next_state == NCR_ST_PWRUP) || (next_state == NCR_ST_RUN) ||
                                (next_state == NCR_ST_HARD)};
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= NCR_ST_OFF;
         pll_cnt <= '0;
         pulse_cnt <= 8'h00;
         first_done <= 1'b0;
         rin_d <= 1'b0;
         rout_n <= 1'b1;
         lrst_n <= 1'b1;
         init_n <= 1'b1;
         keep <= 1'b0;
         core_n <= 1'b0;
         stat <= '0;
      end else if (clk_en) begin
         state <= next_state;
         pll_cnt <= next_pll_cnt;
         pulse_cnt <= next_pulse_cnt;
         first_done <= next_first_done;
         rin_d <= next_rin_d;
         rout_n <= next_rout_n;
         lrst_n <= next_lrst_n;
         init_n <= next_init_n;
         keep <= next_keep;
         core_n <= next_core_n;
         stat <= next_stat;
      end
   end
   assign reset_output_n = rout_n;
   assign local_reset_out_n = lrst_n;
   assign proc_init_n = init_n;
   assign local_mem_keep = keep;
   assign core_reset_n = core_n;

   // Channel clocks are plain counts of the reference, so they track its frequency and
   // any spread-spectrum modulation without gearing.
   logic serial_hold;
   assign serial_hold = (state == NCR_ST_LOCK) || (state == NCR_ST_PWRUP) ||
                        (state == NCR_ST_OFF);
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic [PHW-1:0] ph_cnt, next_ph_cnt;
         logic [15:0] sl_cnt, next_sl_cnt;
         logic ph, next_ph, sy, next_sy, sc, next_sc;
         always_comb begin
            next_ph_cnt = ph_cnt + 1'b1;
            next_ph = ph;
            next_sy = sy;
            if (ph_cnt >= PHW'(PH_DIV - 1)) begin
               next_ph_cnt = '0;
               next_ph = !ph;
               next_sy = ph; // Lags the phase clock by one half period.
            end
            next_sl_cnt = sl_cnt + 1'b1;
            next_sc = sc;
            if (serial_hold) begin
               next_sc = 1'b0;
               next_sl_cnt = '0;
            end else if (channel_fast_req[g]) begin
               next_sc = next_ph;
            end else if (sl_cnt >= 16'(SLOW_DIV - 1)) begin
               next_sl_cnt = '0;
               next_sc = !sc;
            end
            if (!core_n) begin
               next_ph_cnt = '0;
               next_ph = 1'b0;
               next_sy = 1'b0;
            end
         end
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               ph_cnt <= '0;
               sl_cnt <= 16'h0000;
               ph <= 1'b0;
               sy <= 1'b0;
               sc <= 1'b0;
            end else if (clk_en) begin
               ph_cnt <= next_ph_cnt;
               sl_cnt <= next_sl_cnt;
               ph <= next_ph;
               sy <= next_sy;
               sc <= next_sc;
            end
         end
         assign channel_phase_clock[g] = ph;
         assign channel_sync_clock[g] = sy;
         assign channel_serial_clock[g] = sc;
      end
   endgenerate

   // Hub clock divider and fixed-latency capture; the fixed delay keeps reads
   // deterministic whatever the board trace length within one hub period.
   logic [PHW-1:0] hub_cnt, next_hub_cnt;
   logic hub_clk, next_hub_clk;
   logic [1:0] xfer_cnt, next_xfer_cnt;
   logic xfer_busy, next_xfer_busy;
   logic hdat, next_hdat, hval, next_hval;
   logic tck1, tck2, mgd1, mgd2;
   always_comb begin
      next_hub_cnt = hub_cnt + 1'b1;
      next_hub_clk = hub_clk;
      next_xfer_cnt = xfer_cnt;
      next_xfer_busy = xfer_busy;
      next_hdat = hdat;
      next_hval = 1'b0;
      if (hub_cnt >= PHW'(HUB_DIV - 1)) begin
         next_hub_cnt = '0;
         next_hub_clk = !hub_clk;
         if (!hub_clk) begin
            next_xfer_busy = 1'b1;
            next_xfer_cnt = 2'(`NCR_HUB_XFER_CYC - 1);
         end
      end
      if (xfer_busy) begin
         if (xfer_cnt == 2'b00) begin
            next_xfer_busy = 1'b0;
            next_hdat = hdat_s;
            next_hval = 1'b1;
         end else begin
            next_xfer_cnt = xfer_cnt - 2'b01;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hub_cnt <= '0;
         hub_clk <= 1'b0;
         xfer_cnt <= 2'b00;
         xfer_busy <= 1'b0;
         hdat <= 1'b0;
         hval <= 1'b0;
         tck1 <= 1'b0;
         tck2 <= 1'b0;
         mgd1 <= 1'b1;
         mgd2 <= 1'b1;
      end else if (clk_en) begin
         hub_cnt <= next_hub_cnt;
         hub_clk <= next_hub_clk;
         xfer_cnt <= next_xfer_cnt;
         xfer_busy <= next_xfer_busy;
         hdat <= next_hdat;
         hval <= next_hval;
         tck1 <= test_clock;
         tck2 <= tck1;
         mgd1 <= mgmt_data_in;
         mgd2 <= mgd1;
      end
   end
   assign hub_clock_out = hub_clk;
   assign hub_data_core = hdat;
   assign hub_data_valid = hval;
   assign test_clock_core = tck2;
   assign mgmt_data_core = mgd2;
   logic unused_hub_return_clock;
   assign unused_hub_return_clock = hub_return_clock_s;
endmodule // ncr_clock_reset

// file: ncr_far_side.sv
`timescale 1ns/100ps
module ncr_far_side #(
   parameter int TCK_WAIT = 200
) (
   input wire logic clk_sys,
   input wire logic hub_clock_out,
   input wire logic hub_data_next,
   output logic hub_return_clock,
   output logic hub_data_in,
   output logic hub_data_sent,
   output logic test_clock,
   output logic power_good,
   output logic reset_input_n,
   output logic bus_init_n
);
   int n = 0;
   logic run_tck = 1'b0;
   initial begin
      power_good = 1'b0;
      reset_input_n = 1'b0;
      bus_init_n = 1'b1;
      test_clock = 1'b0;
      hub_data_in = 1'b0;
      hub_data_sent = 1'b0;
   end
   // Hub data changes on the falling edge of the returned clock, so it stands through
   // the whole high phase in which the device samples it.
   always @(negedge hub_return_clock) begin
      hub_data_sent <= hub_data_in;
      hub_data_in <= hub_data_next;
   end
   // The delay stands for the trace length through the distribution buffer.
   assign #7 hub_return_clock = hub_clock_out;
   always @(negedge clk_sys) begin
      if (run_tck) begin
         n <= (n == 5) ? 0 : n + 1;
         if (n == 5) test_clock <= ~test_clock;
      end
   end
   task power_up();
      repeat (20000) @(negedge clk_sys);
      power_good = 1'b1;
   endtask
   task set_reset(logic v);
      reset_input_n = v;
   endtask
   task set_bus_init_n(logic v);
      bus_init_n = v;
   endtask
   // The quiet span is scaled down so the run stays short.
   task start_tck();
      repeat (TCK_WAIT) @(negedge clk_sys);
      run_tck = 1'b1;
   endtask
endmodule // ncr_far_side

// file: ncr_params.svh
// How it works
// - Every generated clock is divided from the one 200 MHz reference clock.
// - No clock gearing; all outputs scale with the reference frequency.
// - Each memory channel gets one phase-difference clock pair.
// - Reset clears the channel pair dividers so their phase is deterministic.
// - Channel serial clock runs 1 MHz, or 100 MHz during fast operations.
// - Serial clock held low from power-good until after reset input rises.
// - A 33 MHz hub clock is divided from the core clock and driven out.
// - Hub data moves to core three core cycles after hub clock edge.
// - Test clock is synchronized for private chains; boundary scan uses it directly.
// - Management serial data enters the core through a hardened synchronizer.
// - Reference stable 1 ms before power-good; PLL locks within 1 ms.
// - Second and later reset input assertions are treated as hard resets.
// - System hard reset bit asserts the reset output for a warm reset.
// - Local reset bit warm-hard-resets device, processors, hubs and low-pin parts.
// - Bus init causes a hard reset while local memory stays reachable.
// - Soft reset bit asserts the processor init line when the device drives it.
`ifndef NCR_PARAMS_SVH
`define NCR_PARAMS_SVH
`define NCR_REF_MHZ 200
`define NCR_PHASE_MHZ 100
`define NCR_SERIAL_SLOW_KHZ 1000
`define NCR_HUB_MHZ 33
`define NCR_HUB_XFER_CYC 3
`define NCR_PLL_LOCK_US 1000
`define NCR_RESET_PULSE_CYC 16
`endif

// file: ncr_pkg.sv
package ncr_pkg;
   typedef enum logic [2:0] {
      NCR_ST_OFF = 3'b000,
      NCR_ST_LOCK = 3'b001,
      NCR_ST_PWRUP = 3'b010,
      NCR_ST_RUN = 3'b011,
      NCR_ST_HARD = 3'b100
   } ncr_state_t;
   typedef struct packed {
      logic system_hard_reset_bit;
      logic local_reset_bit;
      logic soft_reset_bit;
      logic init_drive_en;
   } ncr_ctrl_t;
   typedef struct packed {
      logic hard_reset_active;
      logic local_reset_active;
      logic powerup_done;
      logic pll_locked;
   } ncr_stat_t;
endpackage

// file: tb_top.sv
`timescale 1ns/100ps
`include "ncr_params.svh"
module tb_top;
   import ncr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   ncr_ctrl_t ctrl = '0;
   logic [1:0] fast = '0;
   logic mgmt_data_in = 1'b1;
   logic hub_bit = 1'b0;
   logic hub_data_sent;
   logic exp_rout = 1'b1;
   logic exp_init = 1'b1;
   int ssc_cnt = 0;
   logic power_good, reset_input_n, bus_init_n, hub_return_clock, hub_data_in, test_clock;
   logic [1:0] channel_sync_clock, channel_phase_clock, channel_serial_clock;
   logic hub_clock_out, hub_data_core, hub_data_valid, test_clock_core, mgmt_data_core;
   logic reset_output_n, core_reset_n, local_reset_out_n, proc_init_n, local_mem_keep;
   ncr_stat_t stat;
   int fail_count = 0;
   int checks = 0;
   int n, s, h, v;
   logic [31:0] seed = 32'hf01e;
   logic [31:0] r;
   // Every few hundred cycles the half period stretches slightly, standing in for a
   // downspread modulated reference.
   initial forever begin
      #(25.0 + 0.1 * ((ssc_cnt / 333) % 2)) clk_sys = ~clk_sys;
      ssc_cnt++;
   end
   ncr_clock_reset #(.NUM_CH(2), .PLL_LOCK_CYC(20)) u_dut (.clk_sys, .rst_n, .clk_en,
      .power_good, .reset_input_n, .bus_init_n, .ctrl, .channel_fast_req(fast),
      .hub_return_clock, .hub_data_in, .test_clock, .mgmt_data_in, .channel_sync_clock,
      .channel_phase_clock, .channel_serial_clock, .hub_clock_out, .hub_data_core,
      .hub_data_valid, .test_clock_core, .mgmt_data_core, .reset_output_n, .core_reset_n,
      .local_reset_out_n, .proc_init_n, .local_mem_keep, .stat);
   ncr_far_side u_far (.clk_sys, .hub_clock_out, .hub_data_next(hub_bit), .hub_return_clock,
      .hub_data_in, .hub_data_sent, .test_clock, .power_good, .reset_input_n, .bus_init_n);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int edges(int k, int half);
      return k / half;
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic count(int k);
      logic ps;
      logic ph;
      s = 0;
      h = 0;
      v = 0;
      ps = channel_serial_clock[0];
      ph = hub_clock_out;
      repeat (k) begin
         cyc(1);
         if (hub_data_valid === 1'b1) chk("hub_data_core", hub_data_sent, hub_data_core);
         s += (channel_serial_clock[0] !== ps);
         h += (hub_clock_out === 1'b1 && ph === 1'b0);
         v += (hub_data_valid === 1'b1);
         ps = channel_serial_clock[0];
         ph = hub_clock_out;
         r = rnd();
         hub_bit = r[9];
      end
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      cyc(6);
      chk("core_reset_n", 0, core_reset_n);
      chk("reset_output_n", 1, reset_output_n);
      chk("mgmt_data_core", 1, mgmt_data_core);
      rst_n = 1'b1;
      $display("test reset done");
      u_far.power_up();
      cyc(5);
      chk("pll early", 0, stat.pll_locked);
      for (n = 0; n < 30 && stat.pll_locked !== 1'b1; n++) cyc(1);
      chk("pll_locked", 1, stat.pll_locked);
      chk("serial held", 0, channel_serial_clock);
      u_far.set_reset(1'b1);
      fork
         u_far.start_tck();
      join_none
      for (n = 0; n < 30 && core_reset_n !== 1'b1; n++) cyc(1);
      chk("powerup_done", 1, stat.powerup_done);
      $display("test power-up done");
      for (int m = 0; m < 2; m++) begin
         r = rnd();
         fast = {r[7], m[0]};
         cyc(10);
         count(600);
         chk("serial edges", edges(600, m ? 1 : 100), s);
         chk("hub rises", edges(600, 6), h);
         chk("hub valid", edges(600, 6), v);
      end
      clk_en = 1'b0;
      count(10);
      chk("frozen hub", 0, h);
      clk_en = 1'b1;
      $display("test clocks done");
      repeat (24) begin
         r = rnd();
         ctrl = '{r[0], 1'b0, r[1], r[2]};
         mgmt_data_in = r[3];
         // A quarter of the steps run with the clock enable low; the outputs must hold.
         clk_en = r[5] | r[6];
         if (clk_en) begin
            exp_rout = !r[0];
            exp_init = !(r[1] && r[2]);
         end
         cyc(3);
         chk("reset_output_n", exp_rout, reset_output_n);
         chk("proc_init_n", exp_init, proc_init_n);
      end
      ctrl = '0;
      clk_en = 1'b1;
      $display("test control done");
      for (int c = 0; c < 3; c++) begin
         cyc(4);
         if (c == 0) u_far.set_reset(1'b0);
         if (c == 1) ctrl.local_reset_bit = 1'b1;
         if (c == 2) u_far.set_bus_init_n(1'b0);
         for (n = 0; n < 10 && stat.hard_reset_active !== 1'b1; n++) cyc(1);
         chk("hard active", 1, stat.hard_reset_active);
         chk("core held", 0, core_reset_n);
         if (c == 1) begin
            cyc(1);
            chk("local out", 0, local_reset_out_n);
            chk("local active", 1, stat.local_reset_active);
         end
         ctrl.local_reset_bit = 1'b0;
         u_far.set_reset(1'b1);
         u_far.set_bus_init_n(1'b1);
         for (n = 0; n < 60 && core_reset_n !== 1'b1; n++) cyc(1);
         chk("core released", 1, core_reset_n);
         // Slack of three covers the cycles spent detecting the hard state and checking the local outputs before the count starts.
         if (c == 1) chk("pulse", 1, n >= `NCR_RESET_PULSE_CYC - 3);
         chk("local_mem_keep", c == 2, local_mem_keep);
      end
      $display("test hard resets done");
      conclude();
   end
   initial begin
      #(40000 * 50);
      fail_count++;
      conclude();
   end
endmodule // tb_top
